// ### verilog/ifsl_device.sv
// Purpose: Device end of the isolated fast serial link
// Assumes: Link clock is far slower than clock (sampled, edge found)
// Notes:   Channel byte ports use valid/ready; one byte held per side
`timescale 1ns/100ps
module ifsl_device (
  input  wire logic  clock,
  input  wire logic  sys_rst,
  ifsl_link_if.device link,
  input  wire logic  optChanAEn,
  input  wire logic  optChanBEn,
  input  wire logic [7:0] modeCmd,
  input  wire logic  modeCmdWr,
  input  wire logic [7:0] txData,
  input  wire logic  txChan,
  input  wire logic  txValid,
  output logic       txReady,
  output logic [7:0] rxData,
  output logic       rxChan,
  output logic       rxValid,
  input  wire logic  rxReady,
  output logic       linkEnabled
);
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_TX = 2'b01, ST_RX = 2'b11} ifsl_state_t;

  logic        sclk;
  logic        sdi;
  logic        sclkPrev_r;
  logic        rise;
  logic        fall;
  ifsl_state_t state_r;
  ifsl_state_t state_nxt;
  logic [3:0]  cnt_r;
  logic [3:0]  cnt_nxt;
  logic [8:0]  txSh_r;
  logic [8:0]  txSh_nxt;
  logic [8:0]  rxSh_r;
  logic [8:0]  rxSh_nxt;
  logic        sdo_r;
  logic        sdo_nxt;
  logic        cts_r;
  logic        cts_nxt;
  logic        txFull_r;
  logic        txFull_nxt;
  logic [7:0]  txByte_r;
  logic [7:0]  txByte_nxt;
  logic [7:0]  rxData_r;
  logic [7:0]  rxData_nxt;
  logic        txChan_r;
  logic        txChan_nxt;
  logic        rxChan_r;
  logic        rxChan_nxt;
  logic        rxValid_r;
  logic        rxValid_nxt;
  logic        hold_r;
  logic        hold_nxt;
  logic        armed_r;
  logic        armed_nxt;
  logic        active;

  // Link pins pass the three-flop filter
  ifsl_sync3 uClk (.clock(clock), .sys_rst(sys_rst), .rawIn(link.linkClockIn), .cleanOut(sclk));
  ifsl_sync3 uDin (.clock(clock), .sys_rst(sys_rst), .rawIn(link.serialInLine), .cleanOut(sdi));

  // Edge finder on the filtered clock
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sclkPrev_r <= 1'h1;
    end else begin
      sclkPrev_r <= sclk;
    end
  end
  assign rise = sclk & ~sclkPrev_r;
  assign fall = ~sclk & sclkPrev_r;

  // Mode command hold-off; the enables come only from stored options
  always_comb begin
    hold_nxt = hold_r;
    if (modeCmdWr && modeCmd == ifsl_pkg::MODE_RESET) begin
      hold_nxt = 1'h1;
    end else if (modeCmdWr && modeCmd == ifsl_pkg::MODE_RUN) begin
      hold_nxt = 1'h0;
    end
  end
  assign active      = (optChanAEn | optChanBEn) & ~hold_r;
  assign linkEnabled = active;

  // Frame engine; armed means a start is due on the next rising edge
  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    txSh_nxt    = txSh_r;
    rxSh_nxt    = rxSh_r;
    sdo_nxt     = sdo_r;
    cts_nxt     = cts_r;
    armed_nxt   = armed_r;
    txFull_nxt  = txFull_r;
    txByte_nxt  = txByte_r;
    txChan_nxt  = txChan_r;
    rxData_nxt  = rxData_r;
    rxChan_nxt  = rxChan_r;
    rxValid_nxt = rxValid_r;
    if (rxValid_r && rxReady) begin
      rxValid_nxt = 1'h0;
    end
    if (txValid && !txFull_r) begin
      txFull_nxt = 1'h1;
      txByte_nxt = txData;
      txChan_nxt = txChan;
    end
    case (state_r)
      ST_IDLE: begin
        // Last bit of a frame and the start bit both end only on a fall
        if (fall) begin
          sdo_nxt = 1'h1;
        end
        if (!armed_r && fall && txFull_r) begin
          sdo_nxt   = 1'h0;
          armed_nxt = 1'h1;
        end
        if (fall && !rxValid_r) begin
          cts_nxt = 1'h1;
        end
        if (rise && !sdi && cts_r) begin
          state_nxt = ST_RX;
          armed_nxt = 1'h0;
          cts_nxt   = 1'h0;
          cnt_nxt   = 4'h0;
        end else if (rise && armed_r) begin
          state_nxt  = ST_TX;
          armed_nxt  = 1'h0;
          txSh_nxt   = {txChan_r, txByte_r};
          txFull_nxt = 1'h0;
          cnt_nxt    = 4'h0;
        end
      end
      ST_TX: begin
        if (fall) begin
          sdo_nxt  = txSh_r[0];
          txSh_nxt = {1'h1, txSh_r[8:1]};
        end
        if (rise) begin
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r == 4'(ifsl_pkg::DATA_BITS)) begin
            state_nxt = ST_IDLE;
          end
        end
      end
      default: begin
        // A yielded start bit is withdrawn on the next fall, not on a rise
        if (fall) begin
          sdo_nxt = 1'h1;
        end
        if (rise) begin
          rxSh_nxt = {sdi, rxSh_r[8:1]};
          cnt_nxt  = cnt_r + 4'h1;
          if (cnt_r == 4'(ifsl_pkg::DATA_BITS)) begin
            state_nxt   = ST_IDLE;
            rxData_nxt  = rxSh_r[8:1];
            rxChan_nxt  = (sdi == ifsl_pkg::CHAN_A && optChanAEn) ? ifsl_pkg::CHAN_A
                                                                   : ifsl_pkg::CHAN_B;
            rxValid_nxt = 1'h1;
          end
        end
      end
    endcase
  end

  // Register everything; inactive link holds ST_IDLE and its flags at reset values
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hold_r <= 1'h0;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r   <= ST_IDLE;
      cnt_r     <= 4'h0;
      txSh_r    <= 9'h1FF;
      rxSh_r    <= 9'h000;
      sdo_r     <= 1'h1;
      cts_r     <= 1'h0;
      armed_r   <= 1'h0;
      txFull_r  <= 1'h0;
      txByte_r  <= 8'h00;
      txChan_r  <= 1'h0;
      rxData_r  <= 8'h00;
      rxChan_r  <= 1'h0;
      rxValid_r <= 1'h0;
    end else if (!active) begin
      state_r   <= ST_IDLE;
      sdo_r     <= 1'h1;
      cts_r     <= 1'h0;
      armed_r   <= 1'h0;
      txFull_r  <= 1'h0;
      rxValid_r <= 1'h0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      txSh_r    <= txSh_nxt;
      rxSh_r    <= rxSh_nxt;
      sdo_r     <= sdo_nxt;
      cts_r     <= cts_nxt;
      armed_r   <= armed_nxt;
      txFull_r  <= txFull_nxt;
      txByte_r  <= txByte_nxt;
      txChan_r  <= txChan_nxt;
      rxData_r  <= rxData_nxt;
      rxChan_r  <= rxChan_nxt;
      rxValid_r <= rxValid_nxt;
    end
  end

  assign txReady             = active & ~txFull_r;
  assign rxData              = rxData_r;
  assign rxChan              = rxChan_r;
  assign rxValid             = rxValid_r;
  assign link.serialOutLine  = sdo_r;
  assign link.clearToSendOut = cts_r;
endmodule : ifsl_device

// ### include/ifsl_pkg.sv
// Purpose: Shared constants for the isolated fast serial link
// Assumes: One system clock on each end, link clock sampled as data
// Notes:   Frame is start, eight data bits LSB first, channel bit
package ifsl_pkg;
  localparam int          DATA_BITS    = 8;
  localparam int          FRAME_BITS   = 10;
  localparam logic [3:0]  BIT_CNT_LAST = 4'h9;
  localparam logic [7:0]  MODE_RESET   = 8'h10;
  localparam logic [7:0]  MODE_RUN     = 8'h00;
  localparam logic        CHAN_A       = 1'h0;
  localparam logic        CHAN_B       = 1'h1;
  localparam logic [7:0]  HOST_DIV_HALF = 8'h04;
endpackage : ifsl_pkg

// ### include/ifsl_link_if.sv
// Purpose: Four wires between device and external controller
// Assumes: Link clock and frame lines are single-direction wires
// Notes:   Testbench joins both ends through this interface
`timescale 1ns/100ps
interface ifsl_link_if;
  logic linkClockIn;
  logic serialInLine;
  logic serialOutLine;
  logic clearToSendOut;

  modport device (
    input  linkClockIn,
    input  serialInLine,
    output serialOutLine,
    output clearToSendOut
  );
  modport host (
    output linkClockIn,
    output serialInLine,
    input  serialOutLine,
    input  clearToSendOut
  );
endinterface : ifsl_link_if

// ### verilog/ifsl_sync3.sv
// Purpose: Three-flop synchroniser with agreement filter
// Assumes: Input is asynchronous to clock
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/100ps
module ifsl_sync3 (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic rawIn,
  output logic      cleanOut
);
  logic [2:0] stage_r;
  logic [2:0] stage_nxt;
  logic       clean_r;
  logic       clean_nxt;

  // Shift chain; first stage feeds only the second
  always_comb begin
    stage_nxt = {stage_r[1:0], rawIn};
    clean_nxt = (stage_r[1] == stage_r[2]) ? stage_r[2] : clean_r;
  end

  // Reset high so an idle line reads idle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stage_r <= 3'h7;
      clean_r <= 1'h1;
    end else begin
      stage_r <= stage_nxt;
      clean_r <= clean_nxt;
    end
  end

  assign cleanOut = clean_r;
endmodule : ifsl_sync3

// ### verilog/ifsl_host.sv
// Purpose: External controller end: makes link clock, sends, receives
// Assumes: Link clock from a divider of clock
// Notes:   Clock free-runs; stops while a received byte waits unread
`timescale 1ns/100ps
module ifsl_host (
  input  wire logic  clock,
  input  wire logic  sys_rst,
  ifsl_link_if.host  link,
  input  wire logic [7:0] sendData,
  input  wire logic  sendChan,
  input  wire logic  sendValid,
  output logic       sendReady,
  output logic [7:0] gotData,
  output logic       gotChan,
  output logic       gotValid,
  input  wire logic  gotReady
);
  typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_TX = 2'b01, HS_RX = 2'b11} ifsl_hstate_t;

  logic sdo, cts, stall;
  logic [7:0] div_r, div_nxt;
  logic sck_r, sck_nxt, sdi_r, sdi_nxt, gotValid_r, gotValid_nxt, gotChan_r, gotChan_nxt;
  ifsl_hstate_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [9:0] sh_r, sh_nxt;
  logic [7:0] gotData_r, gotData_nxt;
  logic rise, fall;

  ifsl_sync3 uDo  (.clock(clock), .sys_rst(sys_rst), .rawIn(link.serialOutLine), .cleanOut(sdo));
  ifsl_sync3 uCts (.clock(clock), .sys_rst(sys_rst), .rawIn(link.clearToSendOut), .cleanOut(cts));

  // Stall with clock high while a byte cannot be taken
  assign stall = gotValid_r;
  assign rise  = (div_r == ifsl_pkg::HOST_DIV_HALF) & ~sck_r;
  assign fall  = (div_r == ifsl_pkg::HOST_DIV_HALF) & sck_r & ~stall;

  always_comb begin
    div_nxt      = (div_r == ifsl_pkg::HOST_DIV_HALF) ? 8'h00 : div_r + 8'h01;
    sck_nxt      = sck_r ^ (rise | fall);
    sdi_nxt      = sdi_r;
    st_nxt       = st_r;
    cnt_nxt      = cnt_r;
    sh_nxt       = sh_r;
    gotData_nxt  = gotData_r;
    gotChan_nxt  = gotChan_r;
    gotValid_nxt = gotValid_r & ~gotReady;
    case (st_r)
      HS_IDLE: begin
        sdi_nxt = 1'h1;
        if (rise && !sdo) begin
          st_nxt  = HS_RX;
          cnt_nxt = 4'h0;
        end else if (fall && sendValid && cts && sdo) begin
          // Start leaves on the taking fall, so a clash is same-instant
          st_nxt  = HS_TX;
          sdi_nxt = 1'h0;
          sh_nxt  = {1'h1, sendChan, sendData};
          cnt_nxt = 4'h0;
        end
      end
      HS_TX: begin
        if (fall) begin
          sdi_nxt = sh_r[0];
          sh_nxt  = {1'h1, sh_r[9:1]};
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r == ifsl_pkg::BIT_CNT_LAST) begin
            st_nxt  = HS_IDLE;
            sdi_nxt = 1'h1;
          end
        end
      end
      default: begin
        if (rise) begin
          sh_nxt  = {sdo, sh_r[9:1]};
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r == 4'(ifsl_pkg::DATA_BITS)) begin
            st_nxt       = HS_IDLE;
            gotData_nxt  = sh_r[9:2];
            gotChan_nxt  = sdo;
            gotValid_nxt = 1'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      div_r      <= 8'h00;
      sck_r      <= 1'h1;
      sdi_r      <= 1'h1;
      st_r       <= HS_IDLE;
      cnt_r      <= 4'h0;
      sh_r       <= 10'h3FF;
      gotData_r  <= 8'h00;
      gotChan_r  <= 1'h0;
      gotValid_r <= 1'h0;
    end else begin
      div_r      <= div_nxt;
      sck_r      <= sck_nxt;
      sdi_r      <= sdi_nxt;
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      sh_r       <= sh_nxt;
      gotData_r  <= gotData_nxt;
      gotChan_r  <= gotChan_nxt;
      gotValid_r <= gotValid_nxt;
    end
  end

  assign sendReady         = (st_r == HS_IDLE) & fall & sendValid & cts & sdo;
  assign gotData           = gotData_r;
  assign gotChan           = gotChan_r;
  assign gotValid          = gotValid_r;
  assign link.linkClockIn  = sck_r;
  assign link.serialInLine = sdi_r;
endmodule : ifsl_host

// ### tb/ifsl_link_asserts.sv
// Purpose: Wire checks on the link between both ends
// Assumes: Host half period of five clocks
// Notes:   Helper ages link falls and counts host frame bits
`timescale 1ns/100ps
module ifsl_link_asserts (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic linkClockIn,
  input wire logic serialInLine,
  input wire logic serialOutLine,
  input wire logic clearToSendOut
);
  logic       lastClk_r, lastClk_nxt, lastSdi_r, lastSdi_nxt, fall;
  logic [3:0] age_r, age_nxt, rxBit_r, rxBit_nxt;
  // Fall age saturates, so a stopped clock shows up
  always_comb begin
    fall        = lastClk_r && !linkClockIn;
    lastClk_nxt = linkClockIn;
    lastSdi_nxt = serialInLine;
    age_nxt     = fall ? 4'h0 : age_r + {3'h0, age_r != 4'hF};
    rxBit_nxt   = rxBit_r;
    if (rxBit_r != 4'h0 && fall) begin
      rxBit_nxt = (rxBit_r == 4'h9) ? 4'h0 : rxBit_r + 4'h1;
    end else if (rxBit_r == 4'h0 && lastSdi_r && !serialInLine) begin
      rxBit_nxt = 4'h1;
    end
  end
  // Registers only; link idle at reset
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      {lastClk_r, lastSdi_r, age_r, rxBit_r} <= {2'h3, 4'hF, 4'h0};
    end else begin
      {lastClk_r, lastSdi_r, age_r, rxBit_r} <= {lastClk_nxt, lastSdi_nxt, age_nxt, rxBit_nxt};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_clk_half_low: assert property ($fell(linkClockIn) |=> !linkClockIn[*4] ##1 linkClockIn)
    else $error("link clock low phase wrong");
  a_sdi_bit_hold: assert property ($changed(serialInLine) |=> $stable(serialInLine)[*8])
    else $error("host bit too short");
  a_sdi_on_low: assert property ($changed(serialInLine) |-> !linkClockIn)
    else $error("host data moved with clock high");
  a_host_waits_cts: assert property ($fell(serialInLine) && rxBit_r == 4'h0 |-> $past(clearToSendOut))
    else $error("host start without clear");
  a_cts_drop_start: assert property ($fell(serialInLine) |-> ##[1:16] !clearToSendOut)
    else $error("clear did not drop");
  a_cts_low_rx: assert property (rxBit_r > 4'h2 |-> !clearToSendOut)
    else $error("clear high in reception");
  a_half_duplex: assert property (rxBit_r > 4'h2 |-> serialOutLine)
    else $error("device sent in reception");
  a_sdo_on_fall: assert property ($changed(serialOutLine) |-> age_r < 4'h9)
    else $error("device data moved without fall");
  a_cts_rise_fall: assert property ($rose(clearToSendOut) |-> age_r < 4'h9)
    else $error("clear rose without fall");
endmodule : ifsl_link_asserts

// ### tb/isolated_fast_serial_link_bench.sv
// Purpose: Joins both link ends; corner and random traffic
// Assumes: Host makes the link clock from its divider
// Notes:   Expected units are queued when a sender is taken
`timescale 1ns/100ps
module isolated_fast_serial_link_bench;
  logic       clock, sys_rst, optChanAEn, optChanBEn, modeCmdWr, linkEnabled;
  logic [7:0] modeCmd, txData, rxData, sendData, gotData;
  logic       txChan, txValid, txReady, rxChan, rxValid, rxReady;
  logic       sendChan, sendValid, sendReady, gotChan, gotValid, gotReady;
  logic [8:0] toHost[$], toDev[$];
  int         miscompares, n_checks, cyc;
  ifsl_link_if lnk ();
  ifsl_device i_ifsl_device (.clock(clock), .sys_rst(sys_rst), .link(lnk),
    .optChanAEn(optChanAEn), .optChanBEn(optChanBEn), .modeCmd(modeCmd),
    .modeCmdWr(modeCmdWr), .txData(txData), .txChan(txChan), .txValid(txValid),
    .txReady(txReady), .rxData(rxData), .rxChan(rxChan), .rxValid(rxValid),
    .rxReady(rxReady), .linkEnabled(linkEnabled));
  ifsl_host i_ifsl_host (.clock(clock), .sys_rst(sys_rst), .link(lnk),
    .sendData(sendData), .sendChan(sendChan), .sendValid(sendValid),
    .sendReady(sendReady), .gotData(gotData), .gotChan(gotChan),
    .gotValid(gotValid), .gotReady(gotReady));
  ifsl_link_asserts i_ifsl_link_asserts (.clock(clock), .sys_rst(sys_rst),
    .linkClockIn(lnk.linkClockIn), .serialInLine(lnk.serialInLine),
    .serialOutLine(lnk.serialOutLine), .clearToSendOut(lnk.clearToSendOut));
  // Channel a host byte lands on
  function automatic logic route(input logic c, input logic a);
    return (c == ifsl_pkg::CHAN_A && a) ? ifsl_pkg::CHAN_A : ifsl_pkg::CHAN_B;
  endfunction : route
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk_unit(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_unit
  task automatic chk_bit(input logic got, input logic exp);
    chk_unit({8'h00, got}, {8'h00, exp});
  endtask : chk_bit
  // Held until taken; queue entry made on the taking edge
  task automatic dev_send(input logic [7:0] d, input logic c);
    @(negedge clock) {txData, txChan, txValid} = {d, c, 1'h1};
    @(posedge clock);
    while (txReady !== 1'h1) @(posedge clock);
    toHost.push_back({c, d});
    @(negedge clock) txValid = 1'h0;
  endtask : dev_send
  task automatic host_send(input logic [7:0] d, input logic c);
    @(negedge clock) {sendData, sendChan, sendValid} = {d, c, 1'h1};
    @(posedge clock);
    while (sendReady !== 1'h1) @(posedge clock);
    toDev.push_back({route(c, optChanAEn), d});
    @(negedge clock) sendValid = 1'h0;
  endtask : host_send
  task automatic drain();
    for (int i = 0; i < 5000 && (toHost.size() + toDev.size() > 0 || txValid || sendValid); i++)
      @(posedge clock);
    chk_bit(toHost.size() + toDev.size() == 0, 1'h1);
  endtask : drain
  task automatic mode(input logic [7:0] v);
    @(negedge clock) {modeCmd, modeCmdWr} = {v, 1'h1};
    @(negedge clock) modeCmdWr = 1'h0;
  endtask : mode
  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end
  // Receivers compare each unit taken; cycle limit cuts a hang
  always @(posedge clock) begin
    cyc++;
    if (rxValid === 1'h1 && rxReady) begin
      chk_unit({rxChan, rxData}, toDev.size() ? toDev.pop_front() : 'x);
    end
    if (gotValid === 1'h1 && gotReady) begin
      chk_unit({gotChan, gotData}, toHost.size() ? toHost.pop_front() : 'x);
    end
    if (cyc == 40000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    {sys_rst, optChanAEn, optChanBEn, modeCmdWr, rxReady, gotReady} = 6'h38;
    {txData, txChan, txValid, sendData, sendChan, sendValid} = '0;
    modeCmd = ifsl_pkg::MODE_RUN;
    void'($urandom(32'h735071B8));
    repeat (10) @(posedge clock);
    @(negedge clock) sys_rst = 1'h0;
    fork
      forever @(negedge clock) {rxReady, gotReady} = 2'($urandom);
    join_none
    chk_bit(linkEnabled, 1'h1);
    dev_send(8'h00, ifsl_pkg::CHAN_A);
    dev_send(8'hFF, ifsl_pkg::CHAN_B);
    host_send(8'h00, ifsl_pkg::CHAN_A);
    host_send(8'hFF, ifsl_pkg::CHAN_B);
    drain();
    // Both ends busy at once, starts may collide
    fork
      repeat (24) dev_send(8'($urandom), 1'($urandom));
      repeat (24) host_send(8'($urandom), 1'($urandom));
    join
    drain();
    @(negedge clock) optChanAEn = 1'h0;
    host_send(8'h5A, ifsl_pkg::CHAN_A);
    drain();
    @(negedge clock) optChanAEn = 1'h1;
    // Held link takes nothing and clears nothing
    mode(ifsl_pkg::MODE_RESET);
    fork
      dev_send(8'hA5, ifsl_pkg::CHAN_B);
    join_none
    repeat (300) @(posedge clock);
    chk_bit(toHost.size() == 0, 1'h1);
    chk_bit(lnk.clearToSendOut, 1'h0);
    mode(ifsl_pkg::MODE_RUN);
    drain();
    @(negedge clock) {optChanAEn, optChanBEn} = 2'h0;
    // Clear is registered: it reads low one edge after the enables drop
    repeat (2) @(posedge clock);
    chk_bit(linkEnabled, 1'h0);
    chk_bit(lnk.clearToSendOut, 1'h0);
    @(negedge clock) optChanBEn = 1'h1;
    @(posedge clock);
    chk_bit(linkEnabled, 1'h1);
    host_send(8'h3C, ifsl_pkg::CHAN_A);
    dev_send(8'hC3, ifsl_pkg::CHAN_A);
    drain();
    tally_and_finish();
  end
endmodule : isolated_fast_serial_link_bench
